// ### state_timer_pkg.sv
// Constants, register map and carrier types of the state timer front-end
package state_timer_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int HALF_W = 16;
  localparam int NUM_IN = 4;
  localparam int NUM_OUT = 4;
  localparam int NUM_MATCH = 4;
  localparam int NUM_CAP = 4;
  localparam int NUM_DMA = 2;
  localparam int NUM_EV = NUM_MATCH + NUM_IN;
  localparam int IN_IDX_W = 2;
  localparam int PRESCALE_W = 8;
  // Byte offsets of single registers
  localparam logic [ADDR_W-1:0] OFF_SETUP = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_FLAG = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_INTEN = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_INPUT = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_DMA0 = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_DMA1 = 12'h020;
  // Banks of eight words for indexed registers
  localparam int BANK_LSB = 5;
  localparam int IDX_LSB = 2;
  localparam int BANK_W = ADDR_W - BANK_LSB;
  localparam int IDX_W = BANK_LSB - IDX_LSB;
  localparam logic [BANK_W-1:0] BANK_MATCH = 7'h02;
  localparam logic [BANK_W-1:0] BANK_RELOAD = 7'h03;
  localparam logic [BANK_W-1:0] BANK_CAP = 7'h04;
  localparam logic [BANK_W-1:0] BANK_CAPSEL = 7'h05;
  // Setup word layout and reset
  localparam logic [DATA_W-1:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SETUP_USED_MASK = 32'h0000_01FF;
  localparam logic [BE_W-1:0] FULL_WORD_BE = 4'hF;
  localparam int CLOCK_INPUT_EDGE_SELECT_EDGE_BIT = 0;
  localparam int CLOCK_INPUT_EDGE_SELECT_IDX_LSB = 1;
  localparam int CLOCK_INPUT_EDGE_SELECT_BAD_BIT = 3;
  // Control word layout
  localparam int RUN_L_BIT = 0;
  localparam int RUN_H_BIT = 1;
  localparam int PRESCALE_LSB = 8;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CTRL_USED_MASK = 32'h0000_FF03;
  localparam logic [HALF_W-1:0] HALF_ONE = 16'h0001;
  localparam logic [HALF_W-1:0] HALF_TOP = 16'hFFFF;
  localparam logic [DATA_W-1:0] WORD_ONE = 32'h0000_0001;
  localparam logic [PRESCALE_W-1:0] PRESCALE_ONE = 8'h01;

  typedef enum logic [1:0] {
    CM_SYSTEM = 2'b00,
    CM_SAMPLED = 2'b01,
    CM_INPUT = 2'b10,
    CM_ASYNC = 2'b11
  } clock_mode_t;

  typedef struct packed {
    logic [22:0] reserved;
    logic upper_reload_inhibit;
    logic lower_reload_inhibit;
    logic [3:0] clock_input_edge_select;
    clock_mode_t clock_source_mode;
    logic counter_merge_select;
  } setup_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0] be;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage : state_timer_pkg

// ### state_timer_setup_clocking.sv
// State timer setup word, clock front-end, counters and event register groups
// What this block does
// - Merge bit joins two 16-bit halves
// - Mode 0: count on every system clock
// - Mode 1: count only on sampled edges
// - Mode 2: synced edge clocks counters and events, outputs change at once
// - Mode 3: raw edge clocks, outputs follow
// - Select code: bit0 edge, bits 2:1 input, bit3 set blocks ticks
// - Lower inhibit stops reloads, both when merged
// - Upper inhibit stops upper reloads, unmerged only
// - Inhibit bits writable at any time
// - Setup takes word writes, else error
// - Selected events capture counter per register
// - Two DMA lines, one select bit/event
// - Extra DMA bit fires on reload
// - One sticky flag per event
// - Enabled flags request the interrupt
// - Input register reads timer inputs
// - Output register sets and reads outputs
// - Match reloads at each counter cycle start
`timescale 1ns/1ns
`default_nettype none

module state_timer_setup_clocking
  import state_timer_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] bus_addr_in,
  input wire logic [DATA_W-1:0] bus_wdata_in,
  input wire logic [BE_W-1:0] bus_be_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [DATA_W-1:0] bus_rdata_out,
  output logic bus_err_out,
  input wire logic [NUM_IN-1:0] timer_in_in,
  output logic [NUM_OUT-1:0] timer_out_out,
  output logic [NUM_DMA-1:0] dma_req_out,
  output logic irq_out
);

  // ************************************************************
  // Bus decode
  // ************************************************************
  bus_req_t req;
  wire logic [BANK_W-1:0] bank;
  wire logic [IDX_W-1:0] idx;
  wire logic wr_setup;
  wire logic setup_ok;

  // Request bundle and address fields
  assign req = '{addr: bus_addr_in, wdata: bus_wdata_in, be: bus_be_in,
                 wr: bus_wr_in, rd: bus_rd_in};
  assign bank = req.addr[ADDR_W-1:BANK_LSB];
  assign idx = req.addr[BANK_LSB-1:IDX_LSB];
  assign wr_setup = req.wr && (req.addr == OFF_SETUP);
  assign setup_ok = wr_setup && (req.be == FULL_WORD_BE);

  // ************************************************************
  // Setup word and control word
  // ************************************************************
  setup_t setup_reg;
  logic [DATA_W-1:0] ctrl_reg;
  logic err_reg;
  wire clock_mode_t mode;
  wire logic merge;

  assign mode = setup_reg.clock_source_mode;
  assign merge = setup_reg.counter_merge_select;

  // Setup loads only on full-word writes; a partial write errors instead
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      setup_reg <= setup_t'(SETUP_RESET);
      ctrl_reg <= CTRL_RESET;
      err_reg <= 1'b0;
    end else begin
      if (setup_ok) setup_reg <= setup_t'(req.wdata & SETUP_USED_MASK);
      if (req.wr && (req.addr == OFF_CTRL)) ctrl_reg <= req.wdata & CTRL_USED_MASK;
      err_reg <= wr_setup && !setup_ok;
    end
  end

  // ************************************************************
  // Input sampling and clock-input edge
  // ************************************************************
  logic [NUM_IN-1:0] in_meta_reg;
  logic [NUM_IN-1:0] in_sync_reg;
  logic [NUM_IN-1:0] in_prev_reg;
  logic [NUM_IN-1:0] raw_reg;
  logic [NUM_IN-1:0] raw_prev_reg;
  wire logic [IN_IDX_W-1:0] ck_idx;
  wire logic ck_fall;
  wire logic ck_valid;
  wire logic sync_edge;
  wire logic raw_edge;

  // Two-stage synchroniser plus a one-stage sample for the direct mode
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_meta_reg <= '0;
      in_sync_reg <= '0;
      in_prev_reg <= '0;
      raw_reg <= '0;
      raw_prev_reg <= '0;
    end else begin
      in_meta_reg <= timer_in_in;
      in_sync_reg <= in_meta_reg;
      in_prev_reg <= in_sync_reg;
      raw_reg <= timer_in_in;
      raw_prev_reg <= raw_reg;
    end
  end

  // Even codes rise, odd codes fall, input is code over two
  assign ck_idx = setup_reg.clock_input_edge_select[CLOCK_INPUT_EDGE_SELECT_IDX_LSB +: IN_IDX_W];
  assign ck_fall = setup_reg.clock_input_edge_select[CLOCK_INPUT_EDGE_SELECT_EDGE_BIT];
  assign ck_valid = !setup_reg.clock_input_edge_select[CLOCK_INPUT_EDGE_SELECT_BAD_BIT];
  // Pulses of one cycle or more are always seen by the sampler
  assign sync_edge = ck_fall ? (in_prev_reg[ck_idx] && !in_sync_reg[ck_idx])
                             : (!in_prev_reg[ck_idx] && in_sync_reg[ck_idx]);
  // Direct mode trusts the source to run no faster than half rate
  assign raw_edge = ck_fall ? (raw_prev_reg[ck_idx] && !raw_reg[ck_idx])
                            : (!raw_prev_reg[ck_idx] && raw_reg[ck_idx]);

  // ************************************************************
  // Clock scheme: count tick and event enable
  // ************************************************************
  logic tick;
  logic event_en;

  // Mode selects what advances the counters and the event logic
  always_comb begin
    tick = 1'b0;
    event_en = 1'b0;
    case (mode)
      CM_SYSTEM: begin
        tick = 1'b1;
        event_en = 1'b1;
      end
      CM_SAMPLED: begin
        tick = sync_edge && ck_valid;
        event_en = 1'b1;
      end
      CM_INPUT: begin
        tick = sync_edge && ck_valid;
        event_en = tick;
      end
      CM_ASYNC: begin
        tick = raw_edge && ck_valid;
        event_en = tick;
      end
      default: begin
        tick = 1'b0;
        event_en = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Prescaler and counters
  // ************************************************************
  logic [PRESCALE_W-1:0] presc_reg;
  logic [HALF_W-1:0] cnt_l_reg;
  logic [HALF_W-1:0] cnt_h_reg;
  logic [HALF_W-1:0] cnt_l_next;
  logic [HALF_W-1:0] cnt_h_next;
  logic [DATA_W-1:0] match_reg [NUM_MATCH];
  logic [DATA_W-1:0] reload_reg [NUM_MATCH];
  wire logic [PRESCALE_W-1:0] presc_div;
  wire logic adv;
  wire logic adv_l;
  wire logic adv_h;
  wire logic [DATA_W-1:0] cnt_full;
  wire logic limit_u;
  wire logic limit_l;
  wire logic limit_h;
  wire logic start_l;
  wire logic start_h;

  assign presc_div = ctrl_reg[PRESCALE_LSB +: PRESCALE_W];
  assign adv = tick && (presc_reg == presc_div);
  assign adv_l = adv && ctrl_reg[RUN_L_BIT];
  assign adv_h = adv && ctrl_reg[RUN_H_BIT] && !merge;
  assign cnt_full = {cnt_h_reg, cnt_l_reg};
  // Limit is a match on match register 0 of the active width
  assign limit_u = cnt_full == match_reg[0];
  assign limit_l = cnt_l_reg == match_reg[0][HALF_W-1:0];
  assign limit_h = cnt_h_reg == match_reg[0][DATA_W-1:HALF_W];
  assign start_l = adv_l && (merge ? limit_u : limit_l);
  assign start_h = adv_h && limit_h;

  // Next counts: one 32-bit counter or two independent halves
  always_comb begin
    cnt_l_next = cnt_l_reg;
    cnt_h_next = cnt_h_reg;
    if (merge) begin
      if (adv_l) {cnt_h_next, cnt_l_next} = limit_u ? '0 : cnt_full + WORD_ONE;
    end else begin
      if (adv_l) cnt_l_next = limit_l ? '0 : cnt_l_reg + HALF_ONE;
      if (adv_h) cnt_h_next = limit_h ? '0 : cnt_h_reg + HALF_ONE;
    end
  end

  // Prescaler steps on ticks; counters step on prescaler wrap
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      presc_reg <= '0;
      cnt_l_reg <= '0;
      cnt_h_reg <= '0;
    end else begin
      if (tick) presc_reg <= adv ? '0 : presc_reg + PRESCALE_ONE;
      cnt_l_reg <= cnt_l_next;
      cnt_h_reg <= cnt_h_next;
    end
  end

  // ************************************************************
  // Match reload and events
  // ************************************************************
  wire logic reload_lo;
  wire logic reload_hi;
  wire logic reload_any;
  wire logic [NUM_MATCH-1:0] match_wr;
  wire logic [NUM_MATCH-1:0] ev_match;
  wire logic [NUM_IN-1:0] ev_in;
  wire logic [NUM_EV-1:0] events;

  // Lower inhibit covers both halves when merged; upper is then ignored
  assign reload_lo = start_l && !setup_reg.lower_reload_inhibit;
  assign reload_hi = merge ? reload_lo
                           : (start_h && !setup_reg.upper_reload_inhibit);
  assign reload_any = reload_lo || reload_hi;
  assign ev_in = {NUM_IN{event_en}} & in_sync_reg & ~in_prev_reg;
  assign events = {ev_in, ev_match};

  logic [DATA_W-1:0] cap_reg [NUM_CAP];
  logic [NUM_EV-1:0] capsel_reg [NUM_CAP];

  // Per match register: write, reload by halves and compare
  genvar k;
  generate
    for (k = 0; k < NUM_MATCH; k++) begin : g_match
      assign match_wr[k] = req.wr && (bank == BANK_MATCH) && (idx == IDX_W'(k));
      assign ev_match[k] = event_en && (merge ? (cnt_full == match_reg[k]) :
          ((cnt_l_reg == match_reg[k][HALF_W-1:0]) ||
           (cnt_h_reg == match_reg[k][DATA_W-1:HALF_W])));
      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          match_reg[k] <= '0;
          reload_reg[k] <= '0;
        end else begin
          if (match_wr[k]) match_reg[k] <= req.wdata;
          if (reload_lo) match_reg[k][HALF_W-1:0] <= reload_reg[k][HALF_W-1:0];
          if (reload_hi) match_reg[k][DATA_W-1:HALF_W] <= reload_reg[k][DATA_W-1:HALF_W];
          if (req.wr && (bank == BANK_RELOAD) && (idx == IDX_W'(k))) reload_reg[k] <= req.wdata;
        end
      end
    end
    // Per capture register: own event select, copies the count
    for (k = 0; k < NUM_CAP; k++) begin : g_cap
      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          cap_reg[k] <= '0;
          capsel_reg[k] <= '0;
        end else begin
          if (req.wr && (bank == BANK_CAPSEL) && (idx == IDX_W'(k)))
            capsel_reg[k] <= req.wdata[NUM_EV-1:0];
          if (|(events & capsel_reg[k])) cap_reg[k] <= cnt_full;
        end
      end
    end
  endgenerate

  // ************************************************************
  // DMA requests, flags, interrupt, software outputs
  // ************************************************************
  logic [NUM_EV:0] dmasel_reg [NUM_DMA];
  logic [NUM_DMA-1:0] dma_reg;
  logic [NUM_EV-1:0] flag_reg;
  logic [NUM_EV-1:0] inten_reg;
  logic irq_reg;
  logic [NUM_OUT-1:0] out_pend_reg;
  logic [NUM_OUT-1:0] out_reg;
  wire logic [NUM_EV-1:0] flag_next;
  wire logic [NUM_OUT-1:0] out_pend_next;
  wire logic out_apply;
  wire logic [NUM_DMA-1:0] dma_next;
  wire logic [NUM_DMA-1:0] dma_wr;

  assign dma_wr = {req.wr && (req.addr == OFF_DMA1), req.wr && (req.addr == OFF_DMA0)};
  generate
    for (k = 0; k < NUM_DMA; k++) begin : g_dma
      assign dma_next[k] = (|(events & dmasel_reg[k][NUM_EV-1:0])) ||
                           (dmasel_reg[k][NUM_EV] && reload_any);
      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) dmasel_reg[k] <= '0;
        else if (dma_wr[k]) dmasel_reg[k] <= req.wdata[NUM_EV:0];
      end
    end
  endgenerate

  // Write-one clears a flag, but a new event in that cycle wins
  assign flag_next = (flag_reg & ~((req.wr && (req.addr == OFF_FLAG)) ?
                      req.wdata[NUM_EV-1:0] : '0)) | events;
  assign out_pend_next = (req.wr && (req.addr == OFF_OUTPUT)) ?
                         req.wdata[NUM_OUT-1:0] : out_pend_reg;
  // In direct mode the pins only change on the input clock edge
  assign out_apply = (mode != CM_ASYNC) || tick;

  // Flags, enables, requests and output levels
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_reg <= '0;
      inten_reg <= '0;
      irq_reg <= 1'b0;
      dma_reg <= '0;
      out_pend_reg <= '0;
      out_reg <= '0;
    end else begin
      flag_reg <= flag_next;
      if (req.wr && (req.addr == OFF_INTEN)) inten_reg <= req.wdata[NUM_EV-1:0];
      irq_reg <= |(flag_next & inten_reg);
      dma_reg <= dma_next;
      out_pend_reg <= out_pend_next;
      if (out_apply) out_reg <= out_pend_next;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_reg;
  wire logic idx_ok;

  assign idx_ok = idx < IDX_W'(NUM_MATCH);

  // Unmapped addresses read as zero
  always_comb begin
    rd_mux = '0;
    case (req.addr)
      OFF_SETUP: rd_mux = setup_reg;
      OFF_CTRL: rd_mux = ctrl_reg;
      OFF_COUNT: rd_mux = cnt_full;
      OFF_FLAG: rd_mux = DATA_W'(flag_reg);
      OFF_INTEN: rd_mux = DATA_W'(inten_reg);
      OFF_INPUT: rd_mux = DATA_W'(in_sync_reg);
      OFF_OUTPUT: rd_mux = DATA_W'(out_reg);
      OFF_DMA0: rd_mux = DATA_W'(dmasel_reg[0]);
      OFF_DMA1: rd_mux = DATA_W'(dmasel_reg[1]);
      default: begin
        if (idx_ok && (bank == BANK_MATCH)) rd_mux = match_reg[idx[IN_IDX_W-1:0]];
        else if (idx_ok && (bank == BANK_RELOAD)) rd_mux = reload_reg[idx[IN_IDX_W-1:0]];
        else if (idx_ok && (bank == BANK_CAP)) rd_mux = cap_reg[idx[IN_IDX_W-1:0]];
        else if (idx_ok && (bank == BANK_CAPSEL))
          rd_mux = DATA_W'(capsel_reg[idx[IN_IDX_W-1:0]]);
        else rd_mux = '0;
      end
    endcase
  end

  // Read data stand for one cycle after the strobe
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) rdata_reg <= '0;
    else rdata_reg <= req.rd ? rd_mux : '0;
  end

  assign bus_rdata_out = rdata_reg;
  assign bus_err_out = err_reg;
  assign timer_out_out = out_reg;
  assign dma_req_out = dma_reg;
  assign irq_out = irq_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_setup_partial: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (wr_setup && (req.be != FULL_WORD_BE)) |=> (bus_err_out && $stable(setup_reg)))
    else $error("partial setup write not refused");
  a_setup_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
    setup_ok |=> (setup_reg == $past(req.wdata & SETUP_USED_MASK)))
    else $error("setup word did not load");
  a_mode_system: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ((mode == CM_SYSTEM) && !merge && ctrl_reg[RUN_L_BIT] && (presc_reg == presc_div) &&
     !limit_l) |=> (cnt_l_reg == $past(cnt_l_reg) + HALF_ONE))
    else $error("system clock mode missed a tick");
  a_sampled_gate: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ((mode == CM_SAMPLED) && !sync_edge) |=> ($stable(cnt_full) && $stable(presc_reg)))
    else $error("sampled mode ticked without edge");
  a_async_outputs: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ((mode == CM_ASYNC) && !tick) |=> $stable(timer_out_out))
    else $error("outputs moved off the input clock");
  a_merge_carry: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (merge && adv_l && !limit_u && (cnt_l_reg == HALF_TOP))
    |=> (cnt_l_reg == '0) && (cnt_h_reg == $past(cnt_h_reg) + HALF_ONE))
    else $error("merged counter carry lost");
  a_split_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!merge && !adv_h) |=> $stable(cnt_h_reg))
    else $error("upper half moved while idle");
  a_lower_inhibit: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (setup_reg.lower_reload_inhibit && !match_wr[0])
    |=> $stable(match_reg[0][HALF_W-1:0]))
    else $error("lower match reloaded while inhibited");
  a_upper_merged: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (merge && start_l && !setup_reg.lower_reload_inhibit)
    |=> (match_reg[0][DATA_W-1:HALF_W] == $past(reload_reg[0][DATA_W-1:HALF_W])))
    else $error("merged upper reload missing");
  a_flag_sticky: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (|events) |=> ((flag_reg & $past(events)) == $past(events)))
    else $error("event flag not set");
  a_irq_masked: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (inten_reg == '0) |=> !irq_out)
    else $error("interrupt with all enables clear");
  a_dma_reload: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (dmasel_reg[0][NUM_EV] && reload_any) |=> dma_req_out[0])
    else $error("reload did not raise dma request");
  a_capture_copy: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (|(events & capsel_reg[0])) |=> (cap_reg[0] == $past(cnt_full)))
    else $error("capture missed counter value");
  a_input_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (req.rd && (req.addr == OFF_INPUT))
    |=> (bus_rdata_out[NUM_IN-1:0] == $past(in_sync_reg)))
    else $error("input register read wrong");

endmodule : state_timer_setup_clocking

`default_nettype wire

// ### state_timer_setup_clocking_tb.sv
// Self-checking testbench for the state timer setup and clocking block
`timescale 1ns/1ns
`default_nettype none

module state_timer_setup_clocking_tb import state_timer_pkg::*;;
  logic core_clk_in;
  logic rst_in;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [BE_W-1:0] be;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  logic err;
  logic [NUM_IN-1:0] tin;
  logic [NUM_OUT-1:0] tout;
  logic [NUM_DMA-1:0] dma;
  logic irq;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] c0;
  logic last_err;
  int err_count;
  int checks_done;
  int dma0_n;
  int dma1_n;
  // Setup rows: written word beside the value it should read back
  logic [DATA_W-1:0] tab [7][2] = '{'{32'h1, 32'h1}, '{32'h6, 32'h6}, '{32'h78, 32'h78},
    '{32'h80, 32'h80}, '{32'h100, 32'h100}, '{32'hFFFF_FFFF, 32'h1FF}, '{32'h0, 32'h0}};

  state_timer_setup_clocking state_timer_setup_clocking_i (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_be_in(be), .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata), .bus_err_out(err),
    .timer_in_in(tin), .timer_out_out(tout), .dma_req_out(dma), .irq_out(irq));

  // ********************
  // Clock, watchdog and helpers
  // ********************
  initial begin
    core_clk_in = 1'h0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  // Cut a hang short well after the tests should have ended
  initial begin
    repeat (20000) @(posedge core_clk_in);
    err_count++;
    give_verdict();
  end

  // Count DMA request pulses per line
  always @(posedge core_clk_in) begin
    if (dma[0] === 1'h1) dma0_n++;
    if (dma[1] === 1'h1) dma1_n++;
  end

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
                        input logic [BE_W-1:0] b);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= v;
    be <= b;
    wr <= 1'h1;
    @(posedge core_clk_in);
    wr <= 1'h0;
    #1 last_err = err;
  endtask : bus_wr

  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge core_clk_in);
    addr <= a;
    rd <= 1'h1;
    @(posedge core_clk_in);
    rd <= 1'h0;
    #1 v = rdata;
  endtask : bus_rd

  // One-cycle high pulse: a full clock wide at half rate, then quiet while the sync settles
  task automatic pulse(input int k);
    @(posedge core_clk_in);
    tin[k] <= 1'h1;
    @(posedge core_clk_in);
    tin[k] <= 1'h0;
    repeat (6) @(posedge core_clk_in);
  endtask : pulse

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // ********************
  // Test sequence
  // ********************
  initial begin
    rst_in = 1'h1;
    addr = '0;
    wdata = '0;
    be = '0;
    wr = 1'h0;
    rd = 1'h0;
    tin = '0;
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'h0;
    bus_rd(OFF_SETUP, d);
    chk(d, SETUP_RESET);
    chk({27'h0, tout, irq}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      bus_wr(OFF_SETUP, tab[i][0], FULL_WORD_BE);
      chk({31'h0, last_err}, 32'h0);
      bus_rd(OFF_SETUP, d);
      chk(d, tab[i][1]);
    end
    $display("test setup rows done");
    bus_wr(OFF_SETUP, 32'h1, 4'h3);
    chk({31'h0, last_err}, 32'h1);
    bus_rd(OFF_SETUP, d);
    chk(d, 32'h0);
    @(posedge core_clk_in);
    tin <= 4'hA;
    repeat (5) @(posedge core_clk_in);
    bus_rd(OFF_INPUT, d);
    chk(d, 32'hA);
    @(posedge core_clk_in);
    tin <= 4'h0;
    bus_wr(OFF_OUTPUT, 32'h5, FULL_WORD_BE);
    chk({28'h0, tout}, 32'h5);
    bus_rd(OFF_OUTPUT, d);
    chk(d, 32'h5);
    $display("test word write, inputs and outputs done");
    // System clock mode: count steps every cycle
    bus_wr(12'h040, 32'h0000_FFFF, FULL_WORD_BE);
    bus_wr(12'h060, 32'h0000_FFFF, FULL_WORD_BE);
    bus_wr(OFF_CTRL, 32'h1, FULL_WORD_BE);
    bus_rd(OFF_COUNT, c0);
    bus_rd(OFF_COUNT, d);
    chk(d - c0, 32'h2);
    // Edge clocked modes: one tick per selected edge, none while idle
    for (int code = 0; code < 8; code++) begin
      bus_wr(OFF_SETUP, (code << 3) | ((1 + code % 3) << 1), FULL_WORD_BE);
      bus_rd(OFF_COUNT, c0);
      repeat (10) @(posedge core_clk_in);
      bus_rd(OFF_COUNT, d);
      chk(d, c0);
      pulse(code / 2);
      bus_rd(OFF_COUNT, d);
      chk(d, c0 + 32'h1);
    end
    // Direct mode: a written output level waits for the input clock edge
    bus_wr(OFF_SETUP, 32'h6, FULL_WORD_BE);
    bus_wr(OFF_OUTPUT, 32'hA, FULL_WORD_BE);
    chk({28'h0, tout}, 32'h5);
    pulse(0);
    chk({28'h0, tout}, 32'hA);
    $display("test clock modes done");
    // Reload with lower inhibit set, then cleared
    bus_wr(OFF_SETUP, 32'h80, FULL_WORD_BE);
    bus_wr(12'h044, 32'h1111, FULL_WORD_BE);
    bus_wr(12'h064, 32'h2222, FULL_WORD_BE);
    bus_wr(12'h040, 32'h40, FULL_WORD_BE);
    bus_wr(12'h060, 32'h40, FULL_WORD_BE);
    bus_wr(OFF_DMA0, 32'h100, FULL_WORD_BE);
    repeat (150) @(posedge core_clk_in);
    bus_rd(12'h044, d);
    chk({16'h0, d[15:0]}, 32'h1111);
    dma0_n = 0;
    bus_wr(OFF_SETUP, 32'h0, FULL_WORD_BE);
    repeat (150) @(posedge core_clk_in);
    bus_rd(12'h044, d);
    chk({16'h0, d[15:0]}, 32'h2222);
    chk({31'h0, dma0_n > 0}, 32'h1);
    bus_wr(OFF_DMA0, 32'h0, FULL_WORD_BE);
    // Merged counter: upper inhibit is ignored, both halves reload
    bus_wr(OFF_SETUP, 32'h101, FULL_WORD_BE);
    bus_wr(12'h044, 32'h1111_1111, FULL_WORD_BE);
    bus_wr(12'h064, 32'h2222_2222, FULL_WORD_BE);
    repeat (150) @(posedge core_clk_in);
    bus_rd(12'h044, d);
    chk(d, 32'h2222_2222);
    $display("test reload done");
    // Flags, interrupt, DMA event and capture with the counter stopped
    bus_wr(OFF_CTRL, 32'h0, FULL_WORD_BE);
    bus_wr(OFF_INTEN, 32'h10, FULL_WORD_BE);
    bus_wr(OFF_FLAG, 32'hFF, FULL_WORD_BE);
    bus_wr(OFF_DMA1, 32'h20, FULL_WORD_BE);
    bus_wr(12'h0A0, 32'h10, FULL_WORD_BE);
    chk({31'h0, irq}, 32'h0);
    bus_rd(OFF_COUNT, c0);
    dma1_n = 0;
    pulse(0);
    pulse(1);
    bus_rd(OFF_FLAG, d);
    chk(d & 32'h30, 32'h30);
    chk({31'h0, irq}, 32'h1);
    chk(dma1_n, 32'h1);
    bus_rd(12'h080, d);
    chk(d, c0);
    bus_wr(OFF_INTEN, 32'h0, FULL_WORD_BE);
    @(posedge core_clk_in);
    #1 chk({31'h0, irq}, 32'h0);
    $display("test events done");
    // Reset in mid-run: outputs and setup word return to zero
    @(posedge core_clk_in);
    rst_in <= 1'h1;
    repeat (2) @(posedge core_clk_in);
    chk({27'h0, tout, irq}, 32'h0);
    rst_in <= 1'h0;
    bus_rd(OFF_SETUP, d);
    chk(d, SETUP_RESET);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule : state_timer_setup_clocking_tb

`default_nettype wire
